// *** ddma_type_select.sv ***
`timescale 1ns/1ps
// How it works
// - distributed channel ignores isa and pc/pci requests
// - codes 00 isa, 01 pc/pci, 10 distributed
// - channels 7,6,5 at bits 15:14, 13:12, 11:10
// - channels 3..0 at bits 7:6 down to 1:0
// - base pointers at 92h (low), 94h (high)
// - base bits 15:6 compared with io address
// - each window is 64 bytes, 16 per channel
// - slot offsets 00h,10h,20h,30h pick channels 0..3 in the low window, 4..7 in the high
// - channel 4 slot is never claimed
// - base bits 5:0 always read zero
module ddma_type_select
    import ddma_cfg_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire cfg_req_t i_cfg,
    output logic [31:0] o_cfg_rdata,
    output logic o_cfg_claim,
    input wire logic [NUM_CH-1:0] i_isa_dreq,
    input wire logic i_pcpci_req_valid,
    input wire logic [2:0] i_pcpci_req_chan,
    output logic [NUM_CH-1:0] o_isa_dreq,
    output logic o_pcpci_req_valid,
    output logic [2:0] o_pcpci_req_chan,
    output logic [NUM_CH-1:0] o_chan_isa,
    output logic [NUM_CH-1:0] o_chan_pcpci,
    output logic [NUM_CH-1:0] o_chan_dist,
    input wire logic i_io_valid,
    input wire logic [15:0] i_io_addr,
    output logic o_io_claim,
    output logic [2:0] o_io_chan
);

    logic [15:0] type_sel_q, type_sel_d;
    logic [15:0] base_low_q, base_low_d;
    logic [15:0] base_high_q, base_high_d;
    logic [31:0] rdata_q, rdata_d;
    logic claim_q, claim_d;
    logic [NUM_CH-1:0] isa_dreq_q, isa_dreq_d;
    logic pc_valid_q, pc_valid_d;
    logic [2:0] pc_chan_q, pc_chan_d;
    logic [NUM_CH-1:0] isa_w, pcpci_w, dist_w;
    logic [NUM_CH-1:0] isa_sel_q, pcpci_sel_q, dist_sel_q;
    logic io_claim_q, io_claim_d;
    logic [2:0] io_chan_q, io_chan_d;
    win_hit_t win_low, win_high;
    logic [5:0] dw;

    // byte-lane merge of a masked 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wdat,
                                            input logic [1:0] be, input logic [15:0] wmask);
        logic [15:0] v;
        v = old;
        if (be[0]) begin
            v[7:0] = wdat[7:0];
        end
        if (be[1]) begin
            v[15:8] = wdat[15:8];
        end
        merge16 = v & wmask;
    endfunction

    assign dw = i_cfg.addr[7:2];

    // configuration register writes
    always_comb begin
        type_sel_d = type_sel_q;
        base_low_d = base_low_q;
        base_high_d = base_high_q;
        if (i_cfg.wr && dw == DW_TYPE_BASE_LOW) begin
            type_sel_d = merge16(type_sel_q, i_cfg.wdata[15:0], i_cfg.be[1:0],
                                 TYPE_SEL_WMASK);
            base_low_d = merge16(base_low_q, i_cfg.wdata[31:16], i_cfg.be[3:2],
                                 BASE_WMASK);
        end
        if (i_cfg.wr && dw == DW_BASE_HIGH) begin
            base_high_d = merge16(base_high_q, i_cfg.wdata[15:0], i_cfg.be[1:0],
                                  BASE_WMASK);
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            type_sel_q <= TYPE_SEL_RESET;
            base_low_q <= BASE_RESET;
            base_high_q <= BASE_RESET;
        end else begin
            type_sel_q <= type_sel_d;
            base_low_q <= base_low_d;
            base_high_q <= base_high_d;
        end
    end

    // configuration reads, answered one cycle later
    always_comb begin
        rdata_d = 32'h0000_0000;
        claim_d = 1'b0;
        if (i_cfg.rd || i_cfg.wr) begin
            claim_d = (dw == DW_TYPE_BASE_LOW) || (dw == DW_BASE_HIGH);
        end
        if (i_cfg.rd && dw == DW_TYPE_BASE_LOW) begin
            rdata_d = {base_low_q, type_sel_q};
        end
        if (i_cfg.rd && dw == DW_BASE_HIGH) begin
            rdata_d = {16'h0000, base_high_q};
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rdata_q <= 32'h0000_0000;
            claim_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            claim_q <= claim_d;
        end
    end

    chan_type_decode u_type (
        .i_type_sel(type_sel_q),
        .o_isa(isa_w),
        .o_pcpci(pcpci_w),
        .o_dist(dist_w)
    );

    // request gating: distributed channels drop both request paths
    always_comb begin
        isa_dreq_d = i_isa_dreq & ~dist_w;
        pc_valid_d = i_pcpci_req_valid && !dist_w[i_pcpci_req_chan];
        pc_chan_d = i_pcpci_req_valid ? i_pcpci_req_chan : pc_chan_q;
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            isa_dreq_q <= '0;
            pc_valid_q <= 1'b0;
            pc_chan_q <= 3'h0;
            isa_sel_q <= '0;
            pcpci_sel_q <= '0;
            dist_sel_q <= '0;
        end else begin
            isa_dreq_q <= isa_dreq_d;
            pc_valid_q <= pc_valid_d;
            pc_chan_q <= pc_chan_d;
            isa_sel_q <= isa_w;
            pcpci_sel_q <= pcpci_w;
            dist_sel_q <= dist_w;
        end
    end

    ddma_window_decode #(.HIGH_CTRL(1'b0)) u_win_low (
        .i_base(base_low_q),
        .i_io_valid(i_io_valid),
        .i_io_addr(i_io_addr),
        .o_win(win_low)
    );

    ddma_window_decode #(.HIGH_CTRL(1'b1)) u_win_high (
        .i_base(base_high_q),
        .i_io_valid(i_io_valid),
        .i_io_addr(i_io_addr),
        .o_win(win_high)
    );

    // io claim; low controller wins if both windows overlap
    always_comb begin
        io_claim_d = win_low.hit || win_high.hit;
        io_chan_d = io_chan_q;
        if (win_low.hit) begin
            io_chan_d = {1'b0, win_low.slot};
        end else if (win_high.hit) begin
            io_chan_d = {1'b1, win_high.slot};
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            io_claim_q <= 1'b0;
            io_chan_q <= 3'h0;
        end else begin
            io_claim_q <= io_claim_d;
            io_chan_q <= io_chan_d;
        end
    end

    assign o_cfg_rdata = rdata_q;
    assign o_cfg_claim = claim_q;
    assign o_isa_dreq = isa_dreq_q;
    assign o_pcpci_req_valid = pc_valid_q;
    assign o_pcpci_req_chan = pc_chan_q;
    assign o_chan_isa = isa_sel_q;
    assign o_chan_pcpci = pcpci_sel_q;
    assign o_chan_dist = dist_sel_q;
    assign o_io_claim = io_claim_q;
    assign o_io_chan = io_chan_q;

    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    property p_dist_isa_ch7;
        (type_sel_q[15:14] == 2'b10 && i_isa_dreq[7]) |=> !o_isa_dreq[7];
    endproperty
    a_dist_isa_ch7: assert property (p_dist_isa_ch7) else $error("ch7 dreq passed");

    property p_dist_pcpci_ch3;
        (i_pcpci_req_valid && i_pcpci_req_chan == 3'h3 && type_sel_q[7:6] == 2'b10)
            |=> !o_pcpci_req_valid;
    endproperty
    a_dist_pcpci_ch3: assert property (p_dist_pcpci_ch3) else $error("ch3 pcpci passed");

    // sampled reset keeps the attempt at the release edge out, the flops still clear there
    property p_isa_ch0;
        (i_resetn && type_sel_q[1:0] == 2'b00) |=> o_chan_isa[0] && !o_chan_dist[0];
    endproperty
    a_isa_ch0: assert property (p_isa_ch0) else $error("ch0 not isa");

    property p_pcpci_ch5;
        (type_sel_q[11:10] == 2'b01) |=> o_chan_pcpci[5] && !o_chan_isa[5];
    endproperty
    a_pcpci_ch5: assert property (p_pcpci_ch5) else $error("ch5 not pcpci");

    property p_rsvd_isa;
        (type_sel_q[5:4] == 2'b11 && i_isa_dreq[2]) |=> o_isa_dreq[2] && o_chan_isa[2];
    endproperty
    a_rsvd_isa: assert property (p_rsvd_isa) else $error("reserved code not isa");

    property p_base_high_wr;
        (i_cfg.wr && i_cfg.addr == BASE_HIGH_OFF && i_cfg.be[1:0] == 2'b11)
            |=> base_high_q == ($past(i_cfg.wdata[15:0]) & BASE_WMASK);
    endproperty
    a_base_high_wr: assert property (p_base_high_wr) else $error("base high write lost");

    property p_base_low_zero;
        base_low_q[5:0] == 6'h00 && base_high_q[5:0] == 6'h00;
    endproperty
    a_base_low_zero: assert property (p_base_low_zero) else $error("base low bits set");

    property p_rd_base_zero;
        (i_cfg.rd && i_cfg.addr == TYPE_SEL_OFF) |=> o_cfg_rdata[21:16] == 6'h00;
    endproperty
    a_rd_base_zero: assert property (p_rd_base_zero) else $error("base reads nonzero");

    property p_low_hit;
        (i_io_valid && i_io_addr[15:6] == base_low_q[15:6])
            |=> o_io_claim && o_io_chan == {1'b0, $past(i_io_addr[5:4])};
    endproperty
    a_low_hit: assert property (p_low_hit) else $error("low window miss");

    property p_window_size;
        o_io_claim |-> ($past(i_io_addr[15:6]) == $past(base_low_q[15:6]))
            || ($past(i_io_addr[15:6]) == $past(base_high_q[15:6]));
    endproperty
    a_window_size: assert property (p_window_size) else $error("claim outside window");

    property p_no_cascade;
        (i_io_valid && i_io_addr[15:6] == base_high_q[15:6] && i_io_addr[5:4] == 2'b00
            && i_io_addr[15:6] != base_low_q[15:6]) |=> !o_io_claim;
    endproperty
    a_no_cascade: assert property (p_no_cascade) else $error("ch4 slot claimed");

    property p_high_hit;
        (i_io_valid && i_io_addr[15:6] == base_high_q[15:6] && i_io_addr[5:4] != 2'b00
            && i_io_addr[15:6] != base_low_q[15:6])
            |=> o_io_claim && o_io_chan == {1'b1, $past(i_io_addr[5:4])};
    endproperty
    a_high_hit: assert property (p_high_hit) else $error("high window miss");

    property p_io_idle;
        !i_io_valid |=> !o_io_claim;
    endproperty
    a_io_idle: assert property (p_io_idle) else $error("claim without address");

    property p_cfg_idle;
        !(i_cfg.rd || i_cfg.wr) |=> !o_cfg_claim && o_cfg_rdata == 32'h0000_0000;
    endproperty
    a_cfg_idle: assert property (p_cfg_idle) else $error("idle config answered");

    property p_rd_high_upper;
        (i_cfg.rd && i_cfg.addr[7:2] == DW_BASE_HIGH)
            |=> o_cfg_claim && o_cfg_rdata[31:16] == 16'h0000;
    endproperty
    a_rd_high_upper: assert property (p_rd_high_upper) else $error("upper half set");

    // both gated request paths stay quiet on every distributed channel
    property p_dist_quiet;
        (o_isa_dreq & o_chan_dist) == '0;
    endproperty
    a_dist_quiet: assert property (p_dist_quiet) else $error("dist dreq passed");

    property p_pcpci_quiet;
        !(o_pcpci_req_valid && o_chan_dist[o_pcpci_req_chan]);
    endproperty
    a_pcpci_quiet: assert property (p_pcpci_quiet) else $error("dist pcpci passed");

    // every channel carries exactly one type once out of reset
    property p_one_type;
        i_resetn |=> (o_chan_isa | o_chan_pcpci | o_chan_dist) == '1
            && (o_chan_isa & o_chan_pcpci) == '0 && (o_chan_isa & o_chan_dist) == '0
            && (o_chan_pcpci & o_chan_dist) == '0;
    endproperty
    a_one_type: assert property (p_one_type) else $error("type not one-hot");

    property p_cascade_isa;
        i_resetn |=> o_chan_isa[CASCADE_CH] && !o_chan_pcpci[CASCADE_CH]
            && !o_chan_dist[CASCADE_CH];
    endproperty
    a_cascade_isa: assert property (p_cascade_isa) else $error("cascade not isa");

    c_high_slot: cover property (o_io_claim && o_io_chan == 3'h7);
    c_dist_drop: cover property (i_isa_dreq[7] && type_sel_q[15:14] == 2'b10);
    c_pcpci_pass: cover property (o_pcpci_req_valid);
    c_rd_type: cover property (o_cfg_claim && o_cfg_rdata != 32'h0000_0000);

endmodule

// *** ddma_cfg_pkg.sv ***
package ddma_cfg_pkg;

    // configuration space offsets (byte addresses, dword aligned pairs)
    localparam logic [7:0] TYPE_SEL_OFF = 8'h90;
    localparam logic [7:0] BASE_LOW_OFF = 8'h92;
    localparam logic [7:0] BASE_HIGH_OFF = 8'h94;
    localparam logic [5:0] DW_TYPE_BASE_LOW = 6'h24;
    localparam logic [5:0] DW_BASE_HIGH = 6'h25;

    // reset values
    localparam logic [15:0] TYPE_SEL_RESET = 16'h0000;
    localparam logic [15:0] BASE_RESET = 16'h0000;

    // writable bits: type bits 9:8 reserved, base bits 5:0 reserved
    localparam logic [15:0] TYPE_SEL_WMASK = 16'hfcff;
    localparam logic [15:0] BASE_WMASK = 16'hffc0;

    // field positions
    localparam int NUM_CH = 8;
    localparam int TYPE_W = 2;
    localparam int CASCADE_CH = 4;
    localparam int BASE_CMP_LSB = 6;
    localparam int SLOT_LSB = 4;
    localparam int SLOT_W = 2;
    localparam logic [1:0] CASCADE_SLOT = 2'h0;

    // two-bit channel type codes
    typedef enum logic [1:0] {
        DMA_ISA = 2'b00,
        DMA_PCPCI = 2'b01,
        DMA_DIST = 2'b10,
        DMA_RSVD = 2'b11
    } dma_type_t;

    // configuration access, one cycle strobe
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } cfg_req_t;

    // result of the slave window decode
    typedef struct packed {
        logic hit;
        logic [1:0] slot;
    } win_hit_t;

endpackage

// *** chan_type_decode.sv ***
`timescale 1ns/1ps
module chan_type_decode
    import ddma_cfg_pkg::*;
(
    input wire logic [15:0] i_type_sel,
    output logic [NUM_CH-1:0] o_isa,
    output logic [NUM_CH-1:0] o_pcpci,
    output logic [NUM_CH-1:0] o_dist
);

    // map one field to a type; reserved code falls back to isa
    function automatic dma_type_t decode_type(input logic [1:0] code);
        unique case (code)
            2'b01: decode_type = DMA_PCPCI;
            2'b10: decode_type = DMA_DIST;
            default: decode_type = DMA_ISA;
        endcase
    endfunction

    // per channel decode; the cascade channel has no field and stays isa
    always_comb begin
        dma_type_t t;
        t = DMA_ISA;
        for (int ch = 0; ch < NUM_CH; ch++) begin
            if (ch == CASCADE_CH) begin
                t = DMA_ISA;
            end else begin
                t = decode_type(i_type_sel[ch*TYPE_W +: TYPE_W]);
            end
            o_isa[ch] = (t == DMA_ISA);
            o_pcpci[ch] = (t == DMA_PCPCI);
            o_dist[ch] = (t == DMA_DIST);
        end
    end

endmodule

// *** ddma_window_decode.sv ***
`timescale 1ns/1ps
module ddma_window_decode
    import ddma_cfg_pkg::*;
#(
    parameter bit HIGH_CTRL = 1'b0
) (
    input wire logic [15:0] i_base,
    input wire logic i_io_valid,
    input wire logic [15:0] i_io_addr,
    output win_hit_t o_win
);

    logic match;
    logic [SLOT_W-1:0] slot;

    // upper address compare and 16-byte slot pick inside the 64-byte window
    assign match = (i_base[15:BASE_CMP_LSB] == i_io_addr[15:BASE_CMP_LSB]);
    assign slot = i_io_addr[SLOT_LSB +: SLOT_W];
    // cascade slot of the high controller is never claimed
    assign o_win.hit = i_io_valid && match && !(HIGH_CTRL && slot == CASCADE_SLOT);
    assign o_win.slot = slot;

endmodule

// *** req_host_model.sv ***
`timescale 1ns/1ps
// bus master and dma requesters facing the block
module req_host_model
    import ddma_cfg_pkg::*;
(
    input wire logic i_clk,
    output cfg_req_t o_cfg,
    output logic [NUM_CH-1:0] o_dreq,
    output logic o_pc_valid,
    output logic [2:0] o_pc_chan,
    output logic o_io_valid,
    output logic [15:0] o_io_addr
);
    // idle values at time zero
    initial begin
        o_cfg = '0;
        o_dreq = '0;
        o_pc_valid = 1'b0;
        o_pc_chan = 3'h0;
        o_io_valid = 1'b0;
        o_io_addr = 16'h0000;
    end
    // one config strobe; released fields inverted so stale data never matches
    task automatic cfg(input logic wr, input logic [7:0] a, input logic [3:0] be,
                       input logic [31:0] d);
        @(posedge i_clk);
        o_cfg <= '{wr: wr, rd: !wr, addr: a, be: be, wdata: d};
        @(posedge i_clk);
        o_cfg <= '{wr: 1'b0, rd: 1'b0, addr: ~a, be: ~be, wdata: ~d};
    endtask
    // one pc/pci request encoding
    task automatic pcpci(input logic [2:0] c);
        @(posedge i_clk);
        o_pc_valid <= 1'b1;
        o_pc_chan <= c;
        @(posedge i_clk);
        o_pc_valid <= 1'b0;
        o_pc_chan <= ~c;
    endtask
    // one i/o address phase
    task automatic io(input logic [15:0] a);
        @(posedge i_clk);
        o_io_valid <= 1'b1;
        o_io_addr <= a;
        @(posedge i_clk);
        o_io_valid <= 1'b0;
        o_io_addr <= ~a;
    endtask
    // isa request levels, held until changed
    task automatic dreq(input logic [NUM_CH-1:0] r);
        @(posedge i_clk);
        o_dreq <= r;
    endtask
endmodule

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
    import ddma_cfg_pkg::*;
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    cfg_req_t cfg;
    logic [31:0] rdata;
    logic claim, pcv, pcv_o, io_v, io_claim;
    logic [NUM_CH-1:0] dreq, dreq_o, c_isa, c_pc, c_dist;
    logic [2:0] pcc, pcc_o, io_chan;
    logic [15:0] io_a;
    int bad_count = 0;
    int total_checks = 0;

    // 100 MHz clock
    always #5 i_clk = ~i_clk;

    req_host_model pm (.i_clk(i_clk), .o_cfg(cfg), .o_dreq(dreq), .o_pc_valid(pcv),
        .o_pc_chan(pcc), .o_io_valid(io_v), .o_io_addr(io_a));

    ddma_type_select dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_cfg(cfg),
        .o_cfg_rdata(rdata), .o_cfg_claim(claim), .i_isa_dreq(dreq),
        .i_pcpci_req_valid(pcv), .i_pcpci_req_chan(pcc), .o_isa_dreq(dreq_o),
        .o_pcpci_req_valid(pcv_o), .o_pcpci_req_chan(pcc_o), .o_chan_isa(c_isa),
        .o_chan_pcpci(c_pc), .o_chan_dist(c_dist), .i_io_valid(io_v),
        .i_io_addr(io_a), .o_io_claim(io_claim), .o_io_chan(io_chan));

    // value compare
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // config write, then claim
    task automatic cfg_wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d,
                          input logic cl);
        pm.cfg(1'b1, a, be, d);
        #1;
        chk({31'h0, claim}, {31'h0, cl});
    endtask

    // config read, data and claim
    task automatic cfg_rd(input logic [7:0] a, input logic [31:0] exp, input logic cl);
        pm.cfg(1'b0, a, 4'hf, 32'h0000_0000);
        #1;
        chk(rdata, exp);
        chk({31'h0, claim}, {31'h0, cl});
    endtask

    // i/o address decode
    task automatic io_chk(input logic [15:0] a, input logic cl, input logic [2:0] ch);
        pm.io(a);
        #1;
        chk({31'h0, io_claim}, {31'h0, cl});
        if (cl) begin
            chk({29'h0, io_chan}, {29'h0, ch});
        end
    endtask

    // decoded types, gated dma requests and pc/pci path for the current type word
    task automatic type_chk(input logic [7:0] de, input logic [7:0] pe, input logic [7:0] ie);
        chk({24'h0, c_dist}, {24'h0, de});
        chk({24'h0, c_pc}, {24'h0, pe});
        chk({24'h0, c_isa}, {24'h0, ie});
        pm.dreq(8'hff);
        repeat (2) @(posedge i_clk);
        #1;
        chk({24'h0, dreq_o}, {24'h0, ~de});
        pm.dreq(8'h00);
        // every channel through the pc/pci path
        for (int c = 0; c < 8; c++) begin
            pm.pcpci(c[2:0]);
            #1;
            chk({31'h0, pcv_o}, {31'h0, !de[c]});
            if (!de[c]) begin
                chk({29'h0, pcc_o}, {29'h0, c[2:0]});
            end
        end
    endtask

    // verdict
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        #50000;
        bad_count++;
        end_sim();
    end

    // main sequence
    initial begin
        repeat (3) @(posedge i_clk);
        i_resetn <= 1'b1;
        cfg_rd(8'h90, 32'h0000_0000, 1'b1);
        cfg_rd(8'h94, 32'h0000_0000, 1'b1);
        cfg_wr(8'h98, 4'hf, 32'hffff_ffff, 1'b0);
        cfg_rd(8'h98, 32'h0000_0000, 1'b0);
        cfg_wr(8'h90, 4'hf, 32'hffff_9f1b, 1'b1);
        cfg_rd(8'h90, 32'hffc0_9c1b, 1'b1);
        cfg_wr(8'h94, 4'h3, 32'h0000_1234, 1'b1);
        cfg_rd(8'h94, 32'h0000_1200, 1'b1);
        type_chk(8'h82, 8'h44, 8'h39);
        // low window slots, both ends of each
        for (int s = 0; s < 4; s++) begin
            io_chk(16'hffc0 + 16'(s * 16), 1'b1, s[2:0]);
            io_chk(16'hffcf + 16'(s * 16), 1'b1, s[2:0]);
        end
        io_chk(16'h1200, 1'b0, 3'h0);
        io_chk(16'h120f, 1'b0, 3'h0);
        for (int s = 1; s < 4; s++) begin
            io_chk(16'h1200 + 16'(s * 16 + 15), 1'b1, 3'(4 + s));
        end
        io_chk(16'h1240, 1'b0, 3'h0);
        io_chk(16'h11ff, 1'b0, 3'h0);
        io_chk(16'hff80, 1'b0, 3'h0);
        // partial byte write keeps the other byte
        cfg_wr(8'h90, 4'h2, 32'h0000_5500, 1'b1);
        cfg_rd(8'h90, 32'hffc0_541b, 1'b1);
        // second type word: distributed ch3, pc/pci ch1 and ch5, reserved ch2 and ch6
        cfg_wr(8'h90, 4'h3, 32'h0000_37b4, 1'b1);
        cfg_rd(8'h90, 32'hffc0_34b4, 1'b1);
        type_chk(8'h08, 8'h22, 8'hd5);
        end_sim();
    end
endmodule
